// *** pid_loop_defines.vh ***
// constants for the pid loop block
`ifndef PID_LOOP_DEFINES_VH
`define PID_LOOP_DEFINES_VH
`define DW 16
`define FRAC 12
`define ONE_Q 16'sh1000
`define ZERO_Q 16'sh0000
`define OUT_MAX_CODE 12'hFFF
`define ST_IDLE 2'h0
`define ST_CALC 2'h1
`define ST_CLAMP 2'h2
`define ST_STORE 2'h3
`endif

// *** pid_loop_bias_antiwindup.v ***
// position-form pid loop with bias clamping and windup protection
// Functional notes
// - output is gain*error minus rate term plus bias
// - bias starts at initial output, integrates error
// - normalized output clamped to zero..one
// - configurable 12 bit output min/max limits
// - bias clamped to zero..one
// - freeze option holds bias when saturated
// - default back-calculates bias from clamped output
// - error is setpoint minus sampled process variable
// - integral coefficient is gain*period/reset span
// - derivative coefficient is gain*rate span/period
`timescale 1ns/1ps
`include "pid_loop_defines.vh"
module pid_loop_bias_antiwindup (
    input wire clk,
    input wire resetn,
    input wire sample_strobe,
    input wire freeze_bias,
    input wire signed [15:0] setpoint,
    input wire signed [15:0] process_variable,
    input wire signed [15:0] proportional_gain,
    input wire signed [15:0] integral_coefficient,
    input wire signed [15:0] derivative_coefficient,
    input wire signed [15:0] initial_output,
    input wire [11:0] out_min_code,
    input wire [11:0] out_max_code,
    output reg [11:0] control_code,
    output reg signed [15:0] control_norm,
    output reg signed [15:0] bias_term,
    output reg saturated,
    output reg update_done
);
////////////////////////////////////////////////////////////////////////////////
// reset release
reg rst_meta_r;
reg rst_sync_r;
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        rst_meta_r <= 1'b0;
        rst_sync_r <= 1'b0;
    end
    else
    begin
        rst_meta_r <= 1'b1;
        rst_sync_r <= rst_meta_r;
    end
end
////////////////////////////////////////////////////////////////////////////////
// arithmetic, all values q4.12, coefficients computed outside
// the coefficients arrive already formed as gain*ts/ti and gain*td/ts
reg [1:0] state_r;
reg signed [15:0] pv_prev_r;
reg pv_valid_r;
reg signed [15:0] err_r;
reg signed [15:0] dpv_r;
reg signed [39:0] pd_r;
reg signed [39:0] cand_r;
reg signed [39:0] raw_r;
reg signed [16:0] err_nxt;
reg signed [16:0] dpv_nxt;
reg signed [39:0] kp_e_nxt;
reg signed [39:0] kr_d_nxt;
reg signed [39:0] ki_e_nxt;
reg signed [39:0] clamped_nxt;
reg sat_nxt;
reg signed [39:0] bias_pick_nxt;
reg signed [39:0] bias_lim_nxt;
reg [23:0] code_full_nxt;
reg [11:0] code_raw_nxt;
reg [11:0] code_lim_nxt;
wire signed [39:0] one_w = 40'sh0000001000;
wire signed [39:0] zero_w = 40'sh0000000000;
////////////////////////////////////////////////////////////////////////////////
// sample differences
always @*
begin
    err_nxt = {setpoint[15], setpoint} - {process_variable[15], process_variable};
    dpv_nxt = 17'sh00000;
    if (pv_valid_r)
    begin
        // no history on the first sample, so no rate kick
        dpv_nxt = {process_variable[15], process_variable} - {pv_prev_r[15], pv_prev_r};
    end
end
////////////////////////////////////////////////////////////////////////////////
// scaled products, q4.12 times q4.12 shifted back to q4.12
always @*
begin
    kp_e_nxt = (proportional_gain * err_r) >>> `FRAC;
    kr_d_nxt = (derivative_coefficient * dpv_r) >>> `FRAC;
    ki_e_nxt = (integral_coefficient * err_r) >>> `FRAC;
end
////////////////////////////////////////////////////////////////////////////////
// output clamp, windup choice and code scaling
always @*
begin
    clamped_nxt = raw_r;
    sat_nxt = 1'b0;
    if (raw_r < zero_w)
    begin
        clamped_nxt = zero_w;
        sat_nxt = 1'b1;
    end
    else if (raw_r > one_w)
    begin
        clamped_nxt = one_w;
        sat_nxt = 1'b1;
    end
    bias_pick_nxt = cand_r;
    if (sat_nxt)
    begin
        if (freeze_bias)
        begin
            bias_pick_nxt = {{24{bias_term[15]}}, bias_term};
        end
        else
        begin
            // reacts at once when the error turns, but rings after setpoint steps
            bias_pick_nxt = clamped_nxt - pd_r;
        end
    end
    // bias clamp applies in every mode
    bias_lim_nxt = bias_pick_nxt;
    if (bias_pick_nxt < zero_w)
    begin
        bias_lim_nxt = zero_w;
    end
    else if (bias_pick_nxt > one_w)
    begin
        bias_lim_nxt = one_w;
    end
    // full scale is 4095, so 1.0 goes straight to the top code
    code_full_nxt = clamped_nxt[12:0] * 13'h0FFF;
    code_raw_nxt = code_full_nxt[23:12];
    if (clamped_nxt[12])
    begin
        code_raw_nxt = `OUT_MAX_CODE;
    end
    code_lim_nxt = code_raw_nxt;
    if (code_raw_nxt < out_min_code)
    begin
        code_lim_nxt = out_min_code;
    end
    if (code_lim_nxt > out_max_code)
    begin
        code_lim_nxt = out_max_code;
    end
end
////////////////////////////////////////////////////////////////////////////////
// sequencer
always @(posedge clk or negedge rst_sync_r)
begin
    if (!rst_sync_r)
    begin
        state_r <= `ST_IDLE;
        pv_prev_r <= 16'sh0000;
        pv_valid_r <= 1'b0;
        err_r <= 16'sh0000;
        dpv_r <= 16'sh0000;
        pd_r <= 40'sh0000000000;
        cand_r <= 40'sh0000000000;
        raw_r <= 40'sh0000000000;
        control_code <= 12'h000;
        control_norm <= 16'sh0000;
        bias_term <= 16'sh0000;
        saturated <= 1'b0;
        update_done <= 1'b0;
    end
    else
    begin
        update_done <= 1'b0;
        case (state_r)
            `ST_IDLE:
            begin
                if (!pv_valid_r && !update_done)
                begin
                    // every idle cycle after reset, until the first sample, loads the initial output
                    bias_term <= initial_output;
                end
                if (sample_strobe)
                begin
                    err_r <= err_nxt[15:0];
                    dpv_r <= dpv_nxt[15:0];
                    pv_prev_r <= process_variable;
                    pv_valid_r <= 1'b1;
                    state_r <= `ST_CALC;
                end
            end
            `ST_CALC:
            begin
                // strobes during a running update are ignored
                cand_r <= ki_e_nxt + {{24{bias_term[15]}}, bias_term};
                pd_r <= kp_e_nxt - kr_d_nxt;
                state_r <= `ST_CLAMP;
            end
            `ST_CLAMP:
            begin
                raw_r <= pd_r + cand_r;
                state_r <= `ST_STORE;
            end
            `ST_STORE:
            begin
                control_norm <= clamped_nxt[15:0];
                control_code <= code_lim_nxt;
                saturated <= sat_nxt;
                bias_term <= bias_lim_nxt[15:0];
                update_done <= 1'b1;
                state_r <= `ST_IDLE;
            end
            default:
            begin
                state_r <= `ST_IDLE;
            end
        endcase
    end
end
endmodule

// *** pid_chk_sva.sv ***
// port checker for the pid loop
`timescale 1ns/1ps
module pid_chk(
    input wire clk,
    input wire resetn,
    input wire sample_strobe,
    input wire freeze_bias,
    input wire [11:0] control_code,
    input wire signed [15:0] control_norm,
    input wire signed [15:0] bias_term,
    input wire saturated,
    input wire update_done
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
sequence s_hold;
    ##1 (!update_done && $stable(bias_term)) [*3];
endsequence
AST_LAT: assert property (update_done |-> $past(sample_strobe, 4)) else $error("lat");
AST_GAP: assert property (update_done |-> s_hold) else $error("gap");
AST_NORM: assert property (update_done |-> control_norm inside {[0:16'sh1000]}) else $error("n");
AST_BIAS: assert property (update_done |-> bias_term inside {[0:16'sh1000]}) else $error("b");
AST_SAT: assert property (update_done && saturated |-> control_norm inside {0, 16'sh1000})
    else $error("s");
AST_FRZ: assert property (update_done && saturated && freeze_bias |-> $stable(bias_term))
    else $error("f");
AST_HOLD: assert property (!update_done |-> $stable(control_norm)) else $error("h");
AST_CODE: assert property (!update_done |-> $stable(control_code)) else $error("c");
endmodule

// *** proc_plant.sv ***
// process source lagging the control output
`timescale 1ns/1ps
module proc_plant(
    input wire clk,
    input wire resetn,
    input wire update_done,
    input wire signed [15:0] control_norm,
    output reg signed [15:0] process_variable
);
// halfway step keeps the value inside zero..one
always @(posedge clk or negedge resetn)
    if (!resetn)
        process_variable <= 16'sh0800;
    else if (update_done)
        process_variable <= (process_variable + control_norm) >>> 1;
endmodule

// *** tb.sv ***
// random bench for the pid loop
`timescale 1ns/1ps
module tb;
reg clk = 1'h0, resetn = 1'h0, stb = 1'h0, frz = 1'h0;
reg signed [15:0] sv = 16'h0, gp = 16'h0, gi = 16'h0, gd = 16'h0, iv = 16'h0;
reg [11:0] lo = 12'h0, hi = 12'hFFF;
wire [11:0] code;
wire signed [15:0] proc, nrm, bt;
wire sat, done;
integer n_mismatch = 0, checked = 0, cyc = 0, i, b, prv, e, c, r, q;
pid_loop_bias_antiwindup dut(.clk(clk), .resetn(resetn), .sample_strobe(stb), .freeze_bias(frz),
    .setpoint(sv), .process_variable(proc), .proportional_gain(gp), .integral_coefficient(gi),
    .derivative_coefficient(gd), .initial_output(iv), .out_min_code(lo), .out_max_code(hi),
    .control_code(code), .control_norm(nrm), .bias_term(bt), .saturated(sat), .update_done(done));
proc_plant plant(.clk(clk), .resetn(resetn), .update_done(done), .control_norm(nrm),
    .process_variable(proc));
initial forever #2 clk = ~clk;
always @(posedge clk) cyc <= cyc + 1;
task chk(input [15:0] got, input [15:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0t %h %h", $time, got, exp);
    end
endtask
task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
// gains are whole numbers so products are exact whatever the rounding
task step(input bad);
    @(negedge clk);
    sv = i < 4 ? (i % 2) * 4096 : $urandom % 4097;
    gp = (1 + $urandom % 2) * 4096;
    gi = ($urandom % 2) * 4096;
    gd = ($urandom % 2) * 4096;
    frz = $urandom;
    lo = $urandom % 2048;
    hi = lo + $urandom % 2048;
    stb = 1'h1;
    e = sv - proc;
    c = gi * e / 4096 + b;
    r = (gp * e - gd * (proc - prv)) / 4096 + c;
    q = r < 0 ? 0 : r > 4096 ? 4096 : r;
    b = r >= 0 && r <= 4096 ? c : frz ? b : q - r + c;
    b = b < 0 ? 0 : b > 4096 ? 4096 : b;
    prv = proc;
    @(negedge clk) stb = 1'h0;
    if (bad)
    begin
        @(negedge clk) stb = 1'h1;
        @(negedge clk) stb = 1'h0;
    end
    while (done !== 1'h1) @(negedge clk);
    chk(nrm, q);
    chk(bt, b);
    chk(sat, r < 0 || r > 4096);
    q = q * 4095 / 4096;
    chk(code, q < lo ? lo : q > hi ? hi : q);
endtask
initial
begin
    wait (cyc == 999);
    chk(16'h0, 16'h1);
    close_out;
end
initial
begin
    q = $urandom(99);
    iv = $urandom % 4097;
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    repeat (4) @(negedge clk);
    chk(bt, iv);
    b = iv;
    prv = proc;
    for (i = 0; i < 60; i = i + 1)
        step(i % 5 == 3);
    close_out;
end
endmodule
bind pid_loop_bias_antiwindup pid_chk chk_i(.*);
